// ---- rsd_alu_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface rsd_alu_if;
  import rsd_pkg::*;
  logic [7:0] a;
  logic [7:0] b;
  logic       cin;
  logic       with_borrow;
  logic [7:0] diff;
  logic       ov;
  logic       ac;
  logic       c;
  modport core (output a, b, cin, with_borrow, input diff, ov, ac, c);
  modport alu  (input a, b, cin, with_borrow, output diff, ov, ac, c);
endinterface
`default_nettype wire

// ---- rsd_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsd_checker
  import rsd_pkg::*;
#(
  parameter int AW = PC_W
) (
  input wire logic          clk_in,
  input wire logic          arst_n_in,
  input wire logic          op_valid_in,
  input wire logic [4:0]    op_in,
  input wire logic [7:0]    mem_data_in,
  input wire logic [7:0]    imm_in,
  input wire logic [7:0]    table_pointer_in,
  input wire logic          busy_out,
  input wire logic          mem_we_out,
  input wire logic [7:0]    mem_wdata_out,
  input wire logic          prog_re_out,
  input wire logic [AW-1:0] prog_addr_out,
  input wire logic          skip_out,
  input wire logic          dummy_cycle_out,
  input wire logic [7:0]    acc_out,
  input wire logic          flag_c_out,
  input wire logic          flag_z_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  wire take = op_valid_in && !busy_out;
  property p_rla;
    take && op_in == OP_RLA |=> !mem_we_out && $stable(flag_c_out) &&
      acc_out == {$past(mem_data_in[6:0]), $past(mem_data_in[7])};
  endproperty
  a_rla: assert property (p_rla) else $error("rla bad");
  property p_rl_cy;
    take && op_in == OP_RL_CY |=> mem_we_out &&
      flag_c_out == $past(mem_data_in[7]) &&
      mem_wdata_out == {$past(mem_data_in[6:0]), $past(flag_c_out)};
  endproperty
  a_rl_cy: assert property (p_rl_cy) else $error("rotate bad");
  property p_sub;
    take && op_in == OP_SUB |=> acc_out == $past(acc_out - mem_data_in) &&
      flag_c_out == ($past(acc_out) >= $past(mem_data_in));
  endproperty
  a_sub: assert property (p_sub) else $error("sub bad");
  property p_dsz;
    take && op_in == OP_DSZ |=> mem_we_out &&
      skip_out == ($past(mem_data_in) == 8'h01) &&
      mem_wdata_out == $past(mem_data_in) - 8'h01;
  endproperty
  a_dsz: assert property (p_dsz) else $error("dsz bad");
  property p_skip;
    skip_out |-> dummy_cycle_out && busy_out ##1 !dummy_cycle_out;
  endproperty
  a_skip: assert property (p_skip) else $error("no dummy");
  property p_nodummy;
    dummy_cycle_out |-> skip_out;
  endproperty
  a_nodummy: assert property (p_nodummy) else $error("stray dummy");
  property p_xori;
    take && op_in == OP_XORI |=> acc_out == $past(acc_out ^ imm_in) &&
      flag_z_out == (acc_out == 8'h00) && $stable(flag_c_out);
  endproperty
  a_xori: assert property (p_xori) else $error("xori bad");
  property p_tab;
    take && op_in == OP_TRDL |=> prog_re_out &&
      prog_addr_out == {PAGE_LAST, $past(table_pointer_in)};
  endproperty
  a_tab: assert property (p_tab) else $error("table addr bad");
  c_skip: cover property (skip_out);
  c_trdc: cover property (take && op_in == OP_TRDC);
  c_subb_m: cover property (take && op_in == OP_SUBB_M);
endmodule
`default_nettype wire

// ---- rsd_datapath.sv ----
// Summary of operation
// - rotate left to accumulator: memory bit 7 to bit 0, no flags
// - rotate left via carry to memory: carry in bit 0, bit 7 out to carry
// - accumulator form of left carry rotate, memory untouched
// - plain rotate right, bit 0 wraps to bit 7, no flags
// - rotate right via carry: carry to bit 7, bit 0 to carry
// - minus with borrow into accumulator, updates ov z ac c
// - minus with borrow result written to memory, same flags
// - carry cleared when subtraction negative, set when zero or positive
// - subtract memory or immediate without borrow, ov z ac c updated
// - decrement memory, skip on zero, no flags
// - decrement into accumulator, memory unchanged, skip on zero
// - increment to memory or accumulator, skip on zero, no flags
// - taken skip adds one dummy cycle, two cycles total
// - set byte to all ones or one bit to one, no flags
// - skip when selected bit is one
// - skip when byte is zero, nothing changes
// - copy byte to accumulator and skip when zero
// - skip when selected bit is zero
// - swap nibbles to memory or accumulator, no flags
// - table read current page: low byte to memory, high to latch
// - table read last page, same otherwise
// - xor with memory or immediate, only zero flag updated
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module rsd_datapath
  import rsd_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int PW = PROG_W,
  parameter int AW = PC_W
) (
  input  wire logic          clk_in,
  input  wire logic          arst_n_in,
  input  wire logic          op_valid_in,
  input  wire logic [4:0]    op_in,
  input  wire logic [7:0]    mem_data_in,
  input  wire logic [7:0]    imm_in,
  input  wire logic [2:0]    bit_sel_in,
  input  wire logic [AW-1:0] pc_in,
  input  wire logic [7:0]    table_pointer_in,
  input  wire logic [PW-1:0] prog_data_in,
  output logic               busy_out,
  output logic               mem_we_out,
  output logic [7:0]         mem_wdata_out,
  output logic               prog_re_out,
  output logic [AW-1:0]      prog_addr_out,
  output logic               skip_out,
  output logic               dummy_cycle_out,
  output logic [7:0]         acc_out,
  output logic [5:0]         table_upper_byte_latch_out,
  output logic               flag_c_out,
  output logic               flag_ac_out,
  output logic               flag_z_out,
  output logic               flag_ov_out
);
  logic       rst_meta;
  logic       rst_n;
  rsd_state_e state;
  rsd_alu_if  alu ();

  rsd_sub_alu u_alu (
    .p (alu)
  );

  // releasing reset through two flops keeps removal synchronous
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  function automatic logic bit_of(input logic [7:0] v, input logic [2:0] s);
    bit_of = v[s];
  endfunction

  logic [7:0] m;
  logic       go;
  logic [7:0] res;
  logic       wr_mem;
  logic       wr_acc;
  logic       skip;
  logic       upd_c;
  logic       new_c;
  logic       upd_sub;
  logic       upd_z;
  logic [7:0] dec_v;
  logic [7:0] inc_v;

  assign m     = mem_data_in;
  assign go    = op_valid_in && (state == RSD_IDLE);
  assign dec_v = m - 8'h01;
  assign inc_v = m + 8'h01;

  assign alu.a  = acc_out;
  assign alu.b  = (op_in == OP_SUBI) ? imm_in : m;
  assign alu.cin = flag_c_out;
  assign alu.with_borrow = (op_in == OP_SUBB) || (op_in == OP_SUBB_M);

  always_comb begin
    res     = m;
    wr_mem  = 1'b0;
    wr_acc  = 1'b0;
    skip    = 1'b0;
    upd_c   = 1'b0;
    new_c   = flag_c_out;
    upd_sub = 1'b0;
    upd_z   = 1'b0;
    case (op_in)
      OP_RLA: begin
        res    = {m[6:0], m[7]};
        wr_acc = 1'b1;
      end
      OP_RL_CY, OP_RL_CYA: begin
        res    = {m[6:0], flag_c_out};
        upd_c  = 1'b1;
        new_c  = m[7];
        wr_mem = (op_in == OP_RL_CY);
        wr_acc = (op_in == OP_RL_CYA);
      end
      OP_RR, OP_RRA: begin
        res    = {m[0], m[7:1]};
        wr_mem = (op_in == OP_RR);
        wr_acc = (op_in == OP_RRA);
      end
      OP_RR_CY, OP_RR_CYA: begin
        res    = {flag_c_out, m[7:1]};
        upd_c  = 1'b1;
        new_c  = m[0];
        wr_mem = (op_in == OP_RR_CY);
        wr_acc = (op_in == OP_RR_CYA);
      end
      OP_SUBB, OP_SUBB_M, OP_SUB, OP_SUBM, OP_SUBI: begin
        res     = alu.diff;
        upd_sub = 1'b1;
        wr_mem  = (op_in == OP_SUBB_M) || (op_in == OP_SUBM);
        wr_acc  = !wr_mem;
      end
      OP_DSZ, OP_DSZA: begin
        res    = dec_v;
        skip   = (dec_v == 8'h00);
        wr_mem = (op_in == OP_DSZ);
        wr_acc = (op_in == OP_DSZA);
      end
      OP_ISZ, OP_ISZA: begin
        res    = inc_v;
        skip   = (inc_v == 8'h00);
        wr_mem = (op_in == OP_ISZ);
        wr_acc = (op_in == OP_ISZA);
      end
      OP_SET: begin
        res    = ALL_ONES;
        wr_mem = 1'b1;
      end
      OP_SETB: begin
        res             = m;
        res[bit_sel_in] = 1'b1;
        wr_mem          = 1'b1;
      end
      OP_BSO: skip = bit_of(m, bit_sel_in);
      OP_TSTZ: skip = (m == 8'h00);
      OP_MSZ: begin
        wr_acc = 1'b1;
        skip   = (m == 8'h00);
      end
      OP_BSZ: skip = !bit_of(m, bit_sel_in);
      OP_SWAP, OP_SWAPA: begin
        res    = {m[3:0], m[7:4]};
        wr_mem = (op_in == OP_SWAP);
        wr_acc = (op_in == OP_SWAPA);
      end
      OP_XOR, OP_XORM, OP_XORI: begin
        res    = acc_out ^ ((op_in == OP_XORI) ? imm_in : m);
        upd_z  = 1'b1;
        wr_mem = (op_in == OP_XORM);
        wr_acc = !wr_mem;
      end
      default: res = m;
    endcase
  end

  logic is_tbl;
  assign is_tbl = (op_in == OP_TRDC) || (op_in == OP_TRDL);

  // sequencer: taken skip inserts one dummy cycle, table read waits a cycle
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= RSD_IDLE;
    end else begin
      case (state)
        RSD_IDLE: begin
          if (go && skip) begin
            state <= RSD_DUMMY;
          end else if (go && is_tbl) begin
            state <= RSD_TABLE;
          end else begin
            state <= RSD_IDLE;
          end
        end
        default: state <= RSD_IDLE;
      endcase
    end
  end

  assign busy_out        = (state != RSD_IDLE);
  assign dummy_cycle_out = (state == RSD_DUMMY);

  // program address: page from pc for current page, last page otherwise
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prog_re_out   <= 1'b0;
      prog_addr_out <= '0;
    end else begin
      prog_re_out <= go && is_tbl;
      if (go && is_tbl) begin
        if (op_in == OP_TRDL) begin
          prog_addr_out <= {PAGE_LAST, table_pointer_in};
        end else begin
          prog_addr_out <= {pc_in[AW-1:AW-PAGE_W], table_pointer_in};
        end
      end
    end
  end

  // memory write port; table data lands in the cycle after the fetch
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mem_we_out    <= 1'b0;
      mem_wdata_out <= 8'h00;
      skip_out      <= 1'b0;
    end else begin
      mem_we_out <= go && wr_mem;
      skip_out   <= go && skip;
      if (go && wr_mem) begin
        mem_wdata_out <= res;
      end
      if (state == RSD_TABLE) begin
        mem_we_out    <= 1'b1;
        mem_wdata_out <= prog_data_in[7:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      table_upper_byte_latch_out <= 6'h00;
    end else if (state == RSD_TABLE) begin
      table_upper_byte_latch_out <= prog_data_in[PW-1:8];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      acc_out <= ACC_RST;
    end else if (go && wr_acc) begin
      acc_out <= res;
    end
  end

  // flags: only subtraction, carry rotates and xor touch them
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      flag_c_out  <= 1'b0;
      flag_ac_out <= 1'b0;
      flag_z_out  <= 1'b0;
      flag_ov_out <= 1'b0;
    end else if (go) begin
      if (upd_sub) begin
        flag_c_out  <= alu.c;
        flag_ac_out <= alu.ac;
        flag_ov_out <= alu.ov;
        flag_z_out  <= (alu.diff == 8'h00);
      end else if (upd_c) begin
        flag_c_out <= new_c;
      end else if (upd_z) begin
        flag_z_out <= (res == 8'h00);
      end
    end
  end
endmodule
`default_nettype wire

// ---- rsd_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsd_mem_model (
  input  wire logic        clk_in,
  input  wire logic        load_in,
  input  wire logic [7:0]  load_val_in,
  input  wire logic        we_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        re_in,
  input  wire logic [9:0]  addr_in,
  output logic      [7:0]  rdata_out,
  output logic      [13:0] prog_out
);
  logic [13:0] idle_word = 14'h0000;

  // one data cell; a preload from the bench wins over a write-back
  always_ff @(posedge clk_in) begin
    if (load_in)
      rdata_out <= load_val_in;
    else if (we_in)
      rdata_out <= wdata_in;
  end
  // word reads through while the strobe is high, the datapath captures it
  // on the closing edge; otherwise it toggles so a late capture shows up
  always_ff @(posedge clk_in) begin
    idle_word <= ~idle_word;
  end
  assign prog_out = re_in ? {addr_in[5:0], ~addr_in[7:0]} : idle_word;
endmodule
`default_nettype wire

// ---- rsd_pkg.sv ----
package rsd_pkg;
  localparam int DATA_W = 8;
  localparam int PROG_W = 14;
  localparam int PC_W = 10;
  localparam int BIT_W = 3;
  localparam int OP_W = 5;
  localparam int OPERAND_W = 8;

  // operation codes presented on the op port
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_RLA = 5'h01;
  localparam logic [4:0] OP_RL_CY = 5'h02;
  localparam logic [4:0] OP_RL_CYA = 5'h03;
  localparam logic [4:0] OP_RR = 5'h04;
  localparam logic [4:0] OP_RRA = 5'h05;
  localparam logic [4:0] OP_RR_CY = 5'h06;
  localparam logic [4:0] OP_RR_CYA = 5'h07;
  localparam logic [4:0] OP_SUBB = 5'h08;
  localparam logic [4:0] OP_SUBB_M = 5'h09;
  localparam logic [4:0] OP_SUB = 5'h0a;
  localparam logic [4:0] OP_SUBM = 5'h0b;
  localparam logic [4:0] OP_SUBI = 5'h0c;
  localparam logic [4:0] OP_DSZ = 5'h0d;
  localparam logic [4:0] OP_DSZA = 5'h0e;
  localparam logic [4:0] OP_ISZ = 5'h0f;
  localparam logic [4:0] OP_ISZA = 5'h10;
  localparam logic [4:0] OP_SET = 5'h11;
  localparam logic [4:0] OP_SETB = 5'h12;
  localparam logic [4:0] OP_BSO = 5'h13;
  localparam logic [4:0] OP_TSTZ = 5'h14;
  localparam logic [4:0] OP_MSZ = 5'h15;
  localparam logic [4:0] OP_BSZ = 5'h16;
  localparam logic [4:0] OP_SWAP = 5'h17;
  localparam logic [4:0] OP_SWAPA = 5'h18;
  localparam logic [4:0] OP_TRDC = 5'h19;
  localparam logic [4:0] OP_TRDL = 5'h1a;
  localparam logic [4:0] OP_XOR = 5'h1b;
  localparam logic [4:0] OP_XORM = 5'h1c;
  localparam logic [4:0] OP_XORI = 5'h1d;

  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [13:0] PROG_WORD_RST = 14'h0000;
  localparam logic [1:0] PAGE_LAST = 2'h3;
  localparam int PAGE_W = 2;

  typedef enum logic [1:0] {
    RSD_IDLE,
    RSD_DUMMY,
    RSD_TABLE
  } rsd_state_e;
endpackage

// ---- rsd_sub_alu.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsd_sub_alu
  import rsd_pkg::*;
(
  rsd_alu_if.alu p
);
  logic [8:0] full;
  logic [4:0] low;
  logic       bor;

  // borrow in is the inverted carry only for the borrow forms
  assign bor  = p.with_borrow & ~p.cin;
  assign full = {1'b0, p.a} - {1'b0, p.b} - {8'h00, bor};
  assign low  = {1'b0, p.a[3:0]} - {1'b0, p.b[3:0]} - {4'h0, bor};
  assign p.diff = full[7:0];
  // carry is an inverted borrow: set when no borrow out of bit 7
  assign p.c  = ~full[8];
  assign p.ac = ~low[4];
  // signed overflow: borrow into bit 7 differs from borrow out of it
  // borrow into bit 7 is a7 ^ b7 ^ diff7, borrow out of it is full[8]
  assign p.ov = p.a[7] ^ p.b[7] ^ full[7] ^ full[8];
endmodule
`default_nettype wire

// ---- rsd_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rsd_pkg::*;
;
  logic        clk_in = 1'b0, arst_n_in = 1'b0, op_valid_in = 1'b0;
  logic        ld = 1'b0;
  logic [4:0]  op_in = OP_NOP;
  logic [7:0]  imm_in = 8'h00, ldv = 8'h00, table_pointer_in = 8'h4c;
  logic [2:0]  bit_sel_in = 3'h0;
  logic [9:0]  pc_in = 10'h1a7;
  logic [7:0]  mem_data_in, mem_wdata_out, acc_out;
  logic [13:0] prog_data_in;
  logic [9:0]  prog_addr_out;
  logic [5:0]  table_upper_byte_latch_out;
  logic        busy_out, mem_we_out, prog_re_out, skip_out, dummy_cycle_out;
  logic        flag_c_out, flag_ac_out, flag_z_out, flag_ov_out;
  int          mismatches = 0, compares = 0;
  always #4 clk_in = ~clk_in;
  rsd_datapath u_rsd_datapath (.*);
  rsd_mem_model u_rsd_mem_model (
    .clk_in(clk_in), .load_in(ld), .load_val_in(ldv),
    .we_in(mem_we_out), .wdata_in(mem_wdata_out), .re_in(prog_re_out),
    .addr_in(prog_addr_out), .rdata_out(mem_data_in), .prog_out(prog_data_in));
  task automatic chk(input logic [7:0] g, e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // k: 0 no result, 1 accumulator, 2 memory; s: skip expected
  task automatic step(input logic [4:0] o, input logic [7:0] m, x,
    input logic [2:0] b, input int k, input logic [7:0] v, input logic s);
    @(posedge clk_in);
    ld <= 1'b1;
    ldv <= m;
    @(posedge clk_in);
    ld <= 1'b0;
    op_valid_in <= 1'b1;
    op_in <= o;
    imm_in <= x;
    bit_sel_in <= b;
    @(posedge clk_in);
    op_valid_in <= 1'b0;
    #1;
    chk(mem_we_out, k == 2);
    chk(skip_out, s);
    chk(dummy_cycle_out, s);
    chk(k == 2 ? mem_wdata_out : acc_out, v);
  endtask
  task automatic t_arith;
    step(OP_XORI, 8'h00, 8'h5a, 0, 1, 8'h5a, 0);
    step(OP_XORM, 8'h5a, 8'h00, 0, 2, 8'h00, 0);
    chk(flag_z_out, 1);
    step(OP_SUBI, 8'h00, 8'h5b, 0, 1, 8'hff, 0);
    chk(flag_c_out, 0);
    step(OP_SUBB, 8'h0f, 8'h00, 0, 1, 8'hef, 0);
    chk({flag_ov_out, flag_ac_out, flag_c_out}, 3'h1);
    step(OP_SUBB_M, 8'hef, 8'h00, 0, 2, 8'h00, 0);
    chk({flag_c_out, flag_z_out}, 2'h3);
    step(OP_SUB, 8'h0f, 8'h00, 0, 1, 8'he0, 0);
    chk({flag_ov_out, flag_ac_out, flag_c_out}, 3'h3);
    step(OP_SUBI, 8'h00, 8'h61, 0, 1, 8'h7f, 0);
    chk({flag_ov_out, flag_ac_out, flag_c_out}, 3'h5);
    step(OP_SUBM, 8'hf0, 8'h00, 0, 2, 8'h8f, 0);
    chk(flag_c_out, 0);
  endtask
  task automatic t_rot;
    step(OP_RLA, 8'h81, 8'h00, 0, 1, 8'h03, 0);
    step(OP_RL_CY, 8'h80, 8'h00, 0, 2, 8'h00, 0);
    chk(flag_c_out, 1);
    step(OP_RL_CYA, 8'h01, 8'h00, 0, 1, 8'h03, 0);
    step(OP_RR, 8'h01, 8'h00, 0, 2, 8'h80, 0);
    step(OP_RRA, 8'h02, 8'h00, 0, 1, 8'h01, 0);
    step(OP_RR_CY, 8'h01, 8'h00, 0, 2, 8'h00, 0);
    step(OP_RR_CYA, 8'h00, 8'h00, 0, 1, 8'h80, 0);
    chk(flag_c_out, 0);
  endtask
  task automatic t_skip;
    step(OP_DSZ, 8'h01, 8'h00, 0, 2, 8'h00, 1);
    step(OP_DSZ, 8'h02, 8'h00, 0, 2, 8'h01, 0);
    step(OP_DSZA, 8'h01, 8'h00, 0, 1, 8'h00, 1);
    step(OP_ISZ, 8'hff, 8'h00, 0, 2, 8'h00, 1);
    step(OP_ISZA, 8'h00, 8'h00, 0, 1, 8'h01, 0);
    step(OP_SET, 8'h12, 8'h00, 0, 2, 8'hff, 0);
    step(OP_SETB, 8'h00, 8'h00, 3, 2, 8'h08, 0);
    step(OP_BSO, 8'h08, 8'h00, 3, 0, 8'h01, 1);
    step(OP_BSO, 8'hf7, 8'h00, 3, 0, 8'h01, 0);
    step(OP_TSTZ, 8'h00, 8'h00, 0, 0, 8'h01, 1);
    step(OP_MSZ, 8'h00, 8'h00, 0, 1, 8'h00, 1);
    step(OP_BSZ, 8'hf7, 8'h00, 3, 0, 8'h00, 1);
    step(OP_BSZ, 8'h08, 8'h00, 3, 0, 8'h00, 0);
    chk(flag_c_out, 0);
    step(OP_SWAP, 8'h3c, 8'h00, 0, 2, 8'hc3, 0);
    step(OP_SWAPA, 8'h12, 8'h00, 0, 1, 8'h21, 0);
  endtask
  task automatic t_table(input logic [4:0] o, input logic [1:0] pg);
    logic [9:0] a;
    int         n;
    a = {pg, table_pointer_in};
    @(posedge clk_in);
    op_valid_in <= 1'b1;
    op_in <= o;
    @(posedge clk_in);
    op_valid_in <= 1'b0;
    #1;
    chk(prog_re_out, 1);
    chk(prog_addr_out[9:8], pg);
    chk(prog_addr_out[7:0], table_pointer_in);
    for (n = 0; n < 4 && mem_we_out !== 1'b1; n++)
      @(posedge clk_in) #1;
    chk(mem_we_out, 1);
    if (mem_we_out !== 1'b1) begin
      complete_run;
    end else begin
      chk(mem_wdata_out, ~a[7:0]);
      chk(table_upper_byte_latch_out, a[5:0]);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_arith;
    $display("subtract and xor test done");
    t_rot;
    $display("rotate test done");
    t_skip;
    $display("skip and bit test done");
    t_table(OP_TRDC, 2'h1);
    t_table(OP_TRDL, PAGE_LAST);
    $display("table read test done");
    complete_run;
  end
endmodule
bind rsd_datapath rsd_checker #(.AW(AW)) u_rsd_checker (.*);
`default_nettype wire
